/* File: core/sdt_core.v */
/*
 * Data-transfer execution for eight time-shared sequencer channels, with
 * an AHB-Lite slave for control, status and host access to the RAM.
 * Assumes a synchronous RAM with one clock of read latency whose output
 * holds while it is not enabled, and time bases synchronous to SYS_CLK.
 */
// Register access over AHB-Lite and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "sdt_map.vh"
module sdt_core (
	// Clock, reset, enable
	input  wire        SYS_CLK,
	input  wire        ARST_N,
	input  wire        CE,
	// AHB-Lite slave
	input  wire        HSEL,
	input  wire [31:0] HADDR,
	input  wire [1:0]  HTRANS,
	input  wire        HWRITE,
	input  wire [2:0]  HSIZE,
	input  wire [31:0] HWDATA,
	input  wire        HREADY,
	output wire [31:0] HRDATA,
	output wire        HREADYOUT,
	output wire        HRESP,
	// Shared RAM pages
	output wire        RAM_EN,
	output wire        RAM_WE,
	output wire [11:0] RAM_ADDR,
	output wire [31:0] RAM_WDATA,
	input  wire [31:0] RAM_RDATA,
	// Time bases
	input  wire [23:0] TS0,
	input  wire [23:0] TS1,
	input  wire [23:0] TS2,
	// Channel state
	output wire [7:0]  CH_EN,
	output wire [7:0]  CH_ERR
);

	// Per-channel state, indexed by channel, then the shared trigger and accelerate bits
	reg [23:0] gpr_q [0:63];
	reg [13:0] pc_q [0:7];
	reg [31:0] ir_q [0:7];
	reg [31:0] mbuf_q [0:7];
	reg [4:0]  acb_q [0:7];
	reg [7:0]  mhb_q [0:7];
	reg [1:0]  ph_q [0:7];
	reg [7:0]  en_q;
	reg [7:0]  z_q;
	reg [7:0]  err_q;
	reg [15:0] trig_q;
	reg        accel_q;
	// RAM port and read return pipe
	reg        ram_en_q;
	reg        ram_we_q;
	reg [11:0] ram_addr_q;
	reg [31:0] ram_wdata_q;
	reg        rq1_v_q;
	reg        rq1_cpu_q;
	reg        rq1_ir_q;
	reg [2:0]  rq1_ch_q;
	reg        rq2_v_q;
	reg        rq2_cpu_q;
	reg        rq2_ir_q;
	reg [2:0]  rq2_ch_q;
	// Bus data phase
	reg        dp_q;
	reg        dp_ram_q;
	reg        dp_wr_q;
	reg [15:0] dp_addr_q;
	reg        cpu_iss_q;
	reg        cpu_done_q;
	reg [31:0] hrdata_q;
	integer    k;

	wire [2:0]  ch;
	wire        run;
	wire [2:0]  kind;
	wire [3:0]  op_a;
	wire [3:0]  op_b;
	wire [23:0] literal_24bit;
	wire [15:0] literal_16bit;

	sdt_sched u_sched (
		.clk      (SYS_CLK),
		.rst_n    (ARST_N),
		.ce       (CE),
		.accel    (accel_q),
		.ch_en    (en_q),
		.slot_ch  (ch),
		.slot_run (run)
	);

	// Instruction register of the channel in its slot
	sdt_decode u_dec (
		.instr (ir_q[ch]),
		.kind  (kind),
		.op_a  (op_a),
		.op_b  (op_b),
		.literal_24bit (literal_24bit),
		.literal_16bit (literal_16bit)
	);

	// Operation register read for the running channel
	function [23:0] operation_register_set_rd;
		input [2:0] c;
		input [3:0] idx;
		begin
			case (idx)
				`SDT_OR_STA:  operation_register_set_rd = {21'h00_0000, err_q[c], z_q[c], en_q[c]};
				`SDT_OR_ACB:  operation_register_set_rd = {19'h0_0000, acb_q[c]};
				`SDT_OR_TRIGGER_CLEAR_REG: operation_register_set_rd = {8'h00, trig_q};
				`SDT_OR_TRIGGER_SET_REG: operation_register_set_rd = {8'h00, trig_q};
				`SDT_OR_TS0:  operation_register_set_rd = TS0;
				`SDT_OR_TS1:  operation_register_set_rd = TS1;
				`SDT_OR_TS2:  operation_register_set_rd = TS2;
				`SDT_OR_MHB:  operation_register_set_rd = {16'h0000, mhb_q[c]};
				default:      operation_register_set_rd = gpr_q[{c, idx[2:0]}];
			endcase
		end
	endfunction

	wire [23:0] a_val = operation_register_set_rd(ch, op_a);
	wire [23:0] b_val = operation_register_set_rd(ch, op_b);
	wire [13:0] pc_nx = pc_q[ch] + `SDT_PC_STEP;

	// Execute step of the slot's channel
	reg        m_en;
	reg        m_we;
	reg        m_ir;
	reg [11:0] m_addr;
	reg [31:0] m_wdata;
	reg [1:0]  ph_n;
	reg        wr_a;
	reg [23:0] wr_val;
	reg        hb_load;
	reg        step;
	reg        bad;
	always @*
	begin
		m_en    = 1'b0;
		m_we    = 1'b0;
		m_ir    = 1'b0;
		m_addr  = literal_16bit[`SDT_F_WORD];
		m_wdata = {mhb_q[ch], a_val};
		ph_n    = ph_q[ch];
		wr_a    = 1'b0;
		wr_val  = literal_24bit;
		hb_load = 1'b0;
		step    = 1'b0;
		bad     = 1'b0;
		if (run)
		begin
			case (ph_q[ch])
				`SDT_PH_START:
				begin
					m_en   = 1'b1;
					m_ir   = 1'b1;
					m_addr = pc_q[ch][`SDT_F_WORD];
					ph_n   = `SDT_PH_EXEC;
				end
				`SDT_PH_EXEC:
				begin
					case (kind)
						`SDT_K_MOVE_LITERAL_OP:
						begin
							wr_a = 1'b1;
							step = 1'b1;
						end
						`SDT_K_MOV:
						begin
							wr_a   = 1'b1;
							wr_val = b_val;
							step   = 1'b1;
						end
						`SDT_K_MWR:
						begin
							m_en = 1'b1;
							m_we = 1'b1;
							ph_n = `SDT_PH_MEM2;
						end
						`SDT_K_MRD, `SDT_K_MEMORY_WRITE_LOW_OP:
						begin
							m_en = 1'b1;
							ph_n = `SDT_PH_MEM2;
						end
						default: bad = 1'b1;
					endcase
				end
				`SDT_PH_MEM2:
				begin
					if (kind == `SDT_K_MEMORY_WRITE_LOW_OP)
					begin
						m_en    = 1'b1;
						m_we    = 1'b1;
						m_wdata = {mbuf_q[ch][31:24], a_val};
						ph_n    = `SDT_PH_MEM3;
					end
					else
					begin
						wr_a    = (kind == `SDT_K_MRD);
						hb_load = (kind == `SDT_K_MRD);
						wr_val  = mbuf_q[ch][23:0];
						step    = 1'b1;
					end
				end
				default: step = 1'b1;
			endcase
			// Closing step also fetches the next word, hiding fetch latency
			if (step)
			begin
				m_en   = 1'b1;
				m_we   = 1'b0;
				m_ir   = 1'b1;
				m_addr = pc_nx[`SDT_F_WORD];
				ph_n   = `SDT_PH_EXEC;
			end
		end
	end

	// Bus: address phase accept and host grant behind the channels
	wire acc    = HSEL && HTRANS[1] && HREADY;
	wire grant  = CE && dp_q && dp_ram_q && !cpu_iss_q && !m_en;
	wire reg_wr = CE && dp_q && !dp_ram_q && dp_wr_q;
	wire [15:0] ha = HADDR[15:0];
	assign HREADYOUT = !dp_q || !dp_ram_q || (dp_wr_q ? grant : cpu_done_q);
	assign HRESP     = 1'b0;
	assign HRDATA    = hrdata_q;

	// Register read value, chosen in the address phase
	reg [31:0] rd_val;
	always @*
	begin
		rd_val = 32'h0000_0000;
		if (ha == `SDT_A_CTRL)
			rd_val = {31'h0000_0000, accel_q};
		else if (ha == `SDT_A_ENABLE)
			rd_val = {24'h00_0000, en_q};
		else if (ha == `SDT_A_ERROR)
			rd_val = {24'h00_0000, err_q};
		else if (ha == `SDT_A_TRIG)
			rd_val = {16'h0000, trig_q};
		else if (ha[15:5] == `SDT_A_PC_HI)
			rd_val = {18'h0_0000, pc_q[ha[4:2]]};
	end

	// Bus slave state
	always @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			dp_q       <= 1'b0;
			dp_ram_q   <= 1'b0;
			dp_wr_q    <= 1'b0;
			dp_addr_q  <= 16'h0000;
			cpu_iss_q  <= 1'b0;
			cpu_done_q <= 1'b0;
			hrdata_q   <= 32'h0000_0000;
		end
		else if (CE)
		begin
			if (HREADY)
			begin
				dp_q       <= acc;
				dp_ram_q   <= HADDR[`SDT_RAM_WIN];
				dp_wr_q    <= HWRITE;
				dp_addr_q  <= ha;
				cpu_iss_q  <= 1'b0;
				cpu_done_q <= 1'b0;
				if (acc && !HWRITE && !HADDR[`SDT_RAM_WIN])
					hrdata_q <= rd_val;
			end
			else
			begin
				if (grant)
					cpu_iss_q <= 1'b1;
				if (rq2_v_q && rq2_cpu_q)
				begin
					hrdata_q   <= RAM_RDATA;
					cpu_done_q <= 1'b1;
				end
			end
		end
	end

	// RAM port, registered; a host access only takes a free slot
	always @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			ram_en_q    <= 1'b0;
			ram_we_q    <= 1'b0;
			ram_addr_q  <= 12'h000;
			ram_wdata_q <= 32'h0000_0000;
			rq1_v_q     <= 1'b0;
			rq1_cpu_q   <= 1'b0;
			rq1_ir_q    <= 1'b0;
			rq1_ch_q    <= 3'h0;
			rq2_v_q     <= 1'b0;
			rq2_cpu_q   <= 1'b0;
			rq2_ir_q    <= 1'b0;
			rq2_ch_q    <= 3'h0;
		end
		else if (CE)
		begin
			ram_en_q    <= m_en || grant;
			ram_we_q    <= m_en ? m_we : (grant && dp_wr_q); // No strobe without an access
			ram_addr_q  <= m_en ? m_addr : dp_addr_q[`SDT_F_WORD];
			ram_wdata_q <= m_en ? m_wdata : HWDATA;
			rq1_v_q     <= (m_en && !m_we) || (grant && !dp_wr_q);
			rq1_cpu_q   <= !m_en;
			rq1_ir_q    <= m_ir;
			rq1_ch_q    <= ch;
			rq2_v_q     <= rq1_v_q;
			rq2_cpu_q   <= rq1_cpu_q;
			rq2_ir_q    <= rq1_ir_q;
			rq2_ch_q    <= rq1_ch_q;
		end
	end

	// Channel registers; hardware error set is applied last and wins
	always @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			for (k = 0; k < 64; k = k + 1)
				gpr_q[k] <= 24'h00_0000;
			for (k = 0; k < `SDT_NUM_CH; k = k + 1)
			begin
				pc_q[k]   <= 14'h0000;
				ir_q[k]   <= 32'h0000_0000;
				mbuf_q[k] <= 32'h0000_0000;
				acb_q[k]  <= 5'h00;
				mhb_q[k]  <= 8'h00;
				ph_q[k]   <= `SDT_PH_START;
			end
			en_q    <= 8'h00;
			z_q     <= 8'h00;
			err_q   <= 8'h00;
			trig_q  <= 16'h0000;
			accel_q <= 1'b0;
		end
		else if (CE)
		begin
			// Software control
			if (reg_wr && dp_addr_q == `SDT_A_CTRL)
				accel_q <= HWDATA[0];
			if (reg_wr && dp_addr_q[15:5] == `SDT_A_PC_HI)
				pc_q[dp_addr_q[4:2]] <= {HWDATA[13:2], 2'b00};
			if (reg_wr && dp_addr_q == `SDT_A_ENABLE)
				for (k = 0; k < `SDT_NUM_CH; k = k + 1)
				begin
					if (HWDATA[k] && !en_q[k])
					begin
						en_q[k]  <= 1'b1;
						err_q[k] <= 1'b0;
						ph_q[k]  <= `SDT_PH_START;
					end
					else if (!HWDATA[k])
						en_q[k] <= 1'b0;
				end
			// Read data return
			if (rq2_v_q && !rq2_cpu_q)
			begin
				if (rq2_ir_q)
					ir_q[rq2_ch_q] <= RAM_RDATA;
				else
					mbuf_q[rq2_ch_q] <= RAM_RDATA;
			end
			// Execution of the slot's channel
			if (run)
			begin
				ph_q[ch] <= ph_n;
				if (step)
					pc_q[ch] <= pc_nx;
				if (wr_a)
				begin
					case (op_a)
						`SDT_OR_STA:
						begin
							en_q[ch]  <= wr_val[`SDT_STA_EN];
							err_q[ch] <= wr_val[`SDT_STA_ERR];
						end
						`SDT_OR_ACB:  acb_q[ch] <= wr_val[4:0];
						`SDT_OR_TRIGGER_CLEAR_REG: trig_q <= trig_q & ~wr_val[15:0];
						`SDT_OR_TRIGGER_SET_REG: trig_q <= trig_q | wr_val[15:0];
						`SDT_OR_TS0, `SDT_OR_TS1, `SDT_OR_TS2: ;
						`SDT_OR_MHB:  mhb_q[ch] <= wr_val[7:0];
						default:      gpr_q[{ch, op_a[2:0]}] <= wr_val;
					endcase
					z_q[ch] <= (wr_val == 24'h00_0000);
				end
				// High byte from the top of the word unless it is the target
				if (hb_load && op_a != `SDT_OR_MHB)
					mhb_q[ch] <= mbuf_q[ch][31:24];
				if (bad)
				begin
					en_q[ch]  <= 1'b0;
					err_q[ch] <= 1'b1;
				end
			end
		end
	end

	// Outputs
	assign RAM_EN    = ram_en_q;
	assign RAM_WE    = ram_we_q;
	assign RAM_ADDR  = ram_addr_q;
	assign RAM_WDATA = ram_wdata_q;
	assign CH_EN     = en_q;
	assign CH_ERR    = err_q;
endmodule

/* File: core/sdt_map.vh */
/*
 * Constants for the data-transfer decode block of the channel sequencer:
 * instruction fields, opcodes, operand codes, status bits, scheduling
 * figures and the bus map. Assumes inclusion by bare name from core/.
 */
`ifndef SDT_MAP_VH
`define SDT_MAP_VH

// Instruction fields
`define SDT_F_PRIMARY_OPCODE      31:28
`define SDT_F_A         27:24
`define SDT_F_B         23:20
`define SDT_F_SECONDARY_OPCODE      19:16
`define SDT_F_LITERAL_24BIT     23:0
`define SDT_F_LITERAL_16BIT     15:0
`define SDT_F_WORD      13:2

// Opcodes
`define SDT_PRIMARY_OPCODE_MOVE_LITERAL_OP   4'h1
`define SDT_PRIMARY_OPCODE_DBL    4'hA
`define SDT_SECONDARY_OPCODE_MOV    4'h0
`define SDT_SECONDARY_OPCODE_MRD    4'h1
`define SDT_SECONDARY_OPCODE_MWR    4'h2
`define SDT_SECONDARY_OPCODE_MEMORY_WRITE_LOW_OP  4'h7

// Decoded kinds
`define SDT_K_BAD       3'h0
`define SDT_K_MOVE_LITERAL_OP      3'h1
`define SDT_K_MOV       3'h2
`define SDT_K_MRD       3'h3
`define SDT_K_MWR       3'h4
`define SDT_K_MEMORY_WRITE_LOW_OP     3'h5

// Operation register codes
`define SDT_OR_STA      4'h8
`define SDT_OR_ACB      4'h9
`define SDT_OR_TRIGGER_CLEAR_REG     4'hA
`define SDT_OR_TRIGGER_SET_REG     4'hB
`define SDT_OR_TS0      4'hC
`define SDT_OR_TS1      4'hD
`define SDT_OR_TS2      4'hE
`define SDT_OR_MHB      4'hF

// Routing operand ranges
`define SDT_ROUTING_DEST_REGISTER_SET_ZERO   4'h8
`define SDT_ARU_RA_W    9
`define SDT_ARU_WORD_W  53
`define SDT_ARU_WCH_MAX 5'h17

// Status bits
`define SDT_STA_EN      0
`define SDT_STA_Z       1
`define SDT_STA_ERR     2

// Channel phases
`define SDT_PH_START    2'h0
`define SDT_PH_EXEC     2'h1
`define SDT_PH_MEM2     2'h2
`define SDT_PH_MEM3     2'h3

// Scheduling
`define SDT_NUM_CH      8
`define SDT_SLOT_CPU    4'h8
`define SDT_SLOT_LAST   4'h8
`define SDT_HIST_N      4
`define SDT_PC_STEP     14'h0004

// Bus map
`define SDT_A_CTRL      16'h0000
`define SDT_A_ENABLE    16'h0004
`define SDT_A_ERROR     16'h0008
`define SDT_A_TRIG      16'h000C
`define SDT_A_PC_HI     11'h001
`define SDT_RAM_WIN     14

`endif

/* File: core/sdt_decode.v */
/*
 * Field extraction and opcode classification for one instruction word.
 * Purely combinational; the caller supplies the word of the running channel.
 */
`timescale 1ns/10ps
`include "sdt_map.vh"
module sdt_decode (
	// Instruction in
	input  wire [31:0] instr,
	// Decoded out
	output reg  [2:0]  kind,
	output wire [3:0]  op_a,
	output wire [3:0]  op_b,
	output wire [23:0] literal_24bit,
	output wire [15:0] literal_16bit
);

	// Fixed field positions, shared by both formats
	assign op_a  = instr[`SDT_F_A];
	assign literal_24bit = instr[`SDT_F_LITERAL_24BIT];
	assign op_b  = instr[`SDT_F_B];
	assign literal_16bit = instr[`SDT_F_LITERAL_16BIT];

	// Only opcode bits matter; unused fields never reach the kind
	always @*
	begin
		kind = `SDT_K_BAD;
		case (instr[`SDT_F_PRIMARY_OPCODE])
			`SDT_PRIMARY_OPCODE_MOVE_LITERAL_OP: kind = `SDT_K_MOVE_LITERAL_OP;
			`SDT_PRIMARY_OPCODE_DBL:
			begin
				case (instr[`SDT_F_SECONDARY_OPCODE])
					`SDT_SECONDARY_OPCODE_MOV:   kind = `SDT_K_MOV;
					`SDT_SECONDARY_OPCODE_MRD:   kind = `SDT_K_MRD;
					`SDT_SECONDARY_OPCODE_MWR:   kind = `SDT_K_MWR;
					`SDT_SECONDARY_OPCODE_MEMORY_WRITE_LOW_OP: kind = `SDT_K_MEMORY_WRITE_LOW_OP;
					default:         kind = `SDT_K_BAD;
				endcase
			end
			default: kind = `SDT_K_BAD;
		endcase
	end
endmodule

/* File: core/sdt_sched.v */
/*
 * Slot scheduler: nine slots, eight channels plus one host slot.
 * Assumes one slot per clock and that the caller freezes it with ce.
 */
`timescale 1ns/10ps
`include "sdt_map.vh"
module sdt_sched (
	// Clock and reset
	input  wire       clk,
	input  wire       rst_n,
	input  wire       ce,
	// Control
	input  wire       accel,
	input  wire [7:0] ch_en,
	// Current slot
	output wire [2:0] slot_ch,
	output wire       slot_run
);

	reg [3:0]  ptr_q;
	reg [3:0]  ptr_d;
	reg [15:0] hist_q;
	reg [4:0]  pos;
	reg        found;
	reg        recent;
	integer    i;
	integer    j;

	// Next slot; accelerated mode skips stopped or recently served channels
	always @*
	begin
		ptr_d  = ptr_q;
		found  = 1'b0;
		pos    = 5'h00;
		recent = 1'b0;
		for (i = 1; i <= 9; i = i + 1)
		begin
			pos = {1'b0, ptr_q} + i[4:0];
			if (pos > {1'b0, `SDT_SLOT_LAST})
				pos = pos - 5'h09;
			recent = 1'b0;
			for (j = 0; j < `SDT_HIST_N; j = j + 1)
				if (hist_q[j*4 +: 4] == pos[3:0])
					recent = 1'b1;
			if (!found && (!accel || pos[3:0] == `SDT_SLOT_CPU
				|| (ch_en[pos[2:0]] && !recent)))
			begin
				found = 1'b1;
				ptr_d = pos[3:0];
			end
		end
	end

	// History of four slots keeps a channel at least five clocks apart
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ptr_q  <= `SDT_SLOT_CPU;
			hist_q <= 16'hFFFF;
		end
		else if (ce)
		begin
			ptr_q  <= ptr_d;
			hist_q <= {hist_q[11:0], ptr_d};
		end
	end

	assign slot_ch  = ptr_q[2:0];
	assign slot_run = (ptr_q != `SDT_SLOT_CPU) && ch_en[ptr_q[2:0]];
endmodule

/* File: sim/sdt_ram_model.sv */
/*
 * Behavioural model of the shared program and data RAM pages.
 * Assumes word addressing by the block and one clock of read latency.
 */
`timescale 1ns/10ps
module sdt_ram_model (
	// Clock
	input  wire        clk,
	// Access port
	input  wire        en,
	input  wire        we,
	input  wire [11:0] addr,
	input  wire [31:0] wdata,
	output reg  [31:0] rdata
);
	reg     [31:0] mem [0:4095];
	integer        i;

	// Pages start cleared, as after a module reset
	initial
	begin
		for (i = 0; i < 4096; i = i + 1)
			mem[i] = 32'h0000_0000;
		rdata = 32'h0000_0000;
	end

	// Served in arrival order with no locking, so split updates interleave
	always @(posedge clk)
		if (en)
		begin
			if (we)
				mem[addr] <= wdata;
			else
				rdata <= mem[addr];
		end
endmodule

/* File: sim/sdt_core_props.sv */
/*
 * Port checker for the data-transfer sequencer core.
 * Assumes it is bound to sdt_core and sees only that module's ports.
 */
`timescale 1ns/10ps
`include "sdt_map.vh"
module sdt_core_props (
	// Clock and reset
	input wire        SYS_CLK,
	input wire        ARST_N,
	input wire        CE,
	// Register bus
	input wire        HSEL,
	input wire [31:0] HADDR,
	input wire [1:0]  HTRANS,
	input wire        HWRITE,
	input wire        HREADY,
	input wire [31:0] HRDATA,
	input wire        HREADYOUT,
	input wire        HRESP,
	// RAM and channels
	input wire        RAM_EN,
	input wire        RAM_WE,
	input wire [31:0] RAM_RDATA,
	input wire [7:0]  CH_EN,
	input wire [7:0]  CH_ERR
);
	default clocking dc @(posedge SYS_CLK);
	endclocking
	default disable iff (!ARST_N);

	// Accepted request and enable-register write in its data phase
	wire take = CE && HSEL && HTRANS[1] && HREADY;
	wire en_wr_d = take && HWRITE && !HADDR[14] && (HADDR[15:0] == `SDT_A_ENABLE);
	reg  en_wr_q;
	always @(posedge SYS_CLK or negedge ARST_N)
		if (!ARST_N)
			en_wr_q <= 1'b0;
		else if (CE)
			en_wr_q <= en_wr_d;

	// Host RAM read with no channel competing
	sequence s_host_rd;
		take && HADDR[14] && !HWRITE && (CH_EN == 8'h00);
	endsequence
	sequence s_rd_grant;
		!HREADYOUT ##1 (!HREADYOUT && RAM_EN && !RAM_WE) ##1 !HREADYOUT;
	endsequence

	a_host_rd_walk: assert property (s_host_rd |=> s_rd_grant ##1 HREADYOUT)
		else $error("host RAM read sequence wrong");
	a_host_rd_data: assert property (
		s_host_rd |=> ##3 (HRDATA == $past(RAM_RDATA)))
		else $error("host RAM read data wrong");
	a_host_wr_done: assert property (
		take && HADDR[14] && HWRITE && (CH_EN == 8'h00) |=> ##[0:3] (RAM_EN && RAM_WE))
		else $error("host RAM write not issued");
	a_reg_no_wait: assert property (take && !HADDR[14] |=> HREADYOUT)
		else $error("register access stalled");
	a_resp_okay: assert property (HRESP == 1'b0)
		else $error("error response seen");
	a_we_needs_en: assert property (RAM_WE |-> RAM_EN)
		else $error("RAM write without enable");
	a_err_stops_chan: assert property (
		((CH_ERR & ~$past(CH_ERR)) & CH_EN) == 8'h00)
		else $error("faulted channel still enabled");
	a_en_by_host: assert property (
		(CH_EN & ~$past(CH_EN)) != 8'h00 |-> $past(en_wr_q))
		else $error("channel enabled without host write");
	a_err_clr_host: assert property (
		($past(CH_ERR) & ~CH_ERR) != 8'h00 |-> $past(en_wr_q))
		else $error("error cleared without host write");
endmodule

bind sdt_core sdt_core_props sdt_core_props_inst (
	.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .CE(CE), .HSEL(HSEL), .HADDR(HADDR),
	.HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
	.HREADYOUT(HREADYOUT), .HRESP(HRESP), .RAM_EN(RAM_EN), .RAM_WE(RAM_WE),
	.RAM_RDATA(RAM_RDATA), .CH_EN(CH_EN), .CH_ERR(CH_ERR));

/* File: sim/tb_sdt_core.sv */
/*
 * Self-checking bench for the data-transfer sequencer core.
 * Assumes the RAM model on the far side and the bound port checker.
 */
`timescale 1ns/10ps
`include "sdt_map.vh"
module tb_sdt_core;
	reg         sys_clk = 1'b0;
	reg         arst_n = 1'b0;
	reg         hsel = 1'b0;
	reg         hwrite = 1'b0;
	reg  [1:0]  htrans = 2'b00;
	reg  [31:0] haddr = 32'h0000_0000;
	reg  [31:0] hwdata = 32'h0000_0000;
	reg  [23:0] ts0 = 24'h10_0001;
	reg  [23:0] ts1 = 24'h2B_3C4D;
	reg  [23:0] ts2 = 24'h30_0003;
	reg  [31:0] rd;
	wire [31:0] hrdata, ram_wdata, ram_rdata;
	wire        hreadyout, hresp, ram_en, ram_we;
	wire [11:0] ram_addr;
	wire [7:0]  ch_en, ch_err;
	integer     n_fail = 0, checks = 0, cyc = 0, t_a = 0, t_b = 0, w;

	always #25 sys_clk = ~sys_clk;

	// Single slave: its ready is the bus ready
	sdt_core sdt_core_inst (
		.SYS_CLK(sys_clk), .ARST_N(arst_n), .CE(1'b1), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata),
		.HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
		.RAM_EN(ram_en), .RAM_WE(ram_we), .RAM_ADDR(ram_addr), .RAM_WDATA(ram_wdata),
		.RAM_RDATA(ram_rdata), .TS0(ts0), .TS1(ts1), .TS2(ts2), .CH_EN(ch_en),
		.CH_ERR(ch_err));
	sdt_ram_model sdt_ram_model_inst (.clk(sys_clk), .en(ram_en), .we(ram_we),
		.addr(ram_addr), .wdata(ram_wdata), .rdata(ram_rdata));

	// Fetch stamps of two neighbouring program words
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (ram_en && !ram_we && ram_addr == 12'h022)
			t_a <= cyc;
		if (ram_en && !ram_we && ram_addr == 12'h023)
			t_b <= cyc;
	end

	task final_report;
	begin
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask

	task chk(input string what, input [31:0] seen, input [31:0] exp);
	begin
		checks = checks + 1;
		if (seen !== exp)
		begin
			n_fail = n_fail + 1;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	end
	endtask

	// Sampled at the falling edge so the rising edge finds it settled
	task wait_rdy;
		integer n;
	begin
		n = 0;
		@(negedge sys_clk);
		while (hreadyout !== 1'b1 && n < 500)
		begin
			n = n + 1;
			@(negedge sys_clk);
		end
		if (n >= 500)
			n_fail = n_fail + 1;
		rd = hrdata;
		@(posedge sys_clk);
	end
	endtask

	task xfer(input [15:0] a, input wr, input [31:0] wd);
	begin
		hsel <= 1'b1;
		haddr <= {16'h0000, a};
		htrans <= 2'b10;
		hwrite <= wr;
		wait_rdy;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_rdy;
	end
	endtask

	task rdc(input string what, input [15:0] a, input [31:0] exp);
	begin
		xfer(a, 1'b0, 32'h0000_0000);
		chk(what, rd, exp);
	end
	endtask

	task ramw(input [11:0] wa, input [31:0] d);
		xfer({2'b01, wa, 2'b00}, 1'b1, d);
	endtask

	task wait_off(input integer b);
		integer n;
	begin
		n = 0;
		@(negedge sys_clk);
		while (ch_en[b] !== 1'b0 && n < 3000)
		begin
			n = n + 1;
			@(negedge sys_clk);
		end
		if (n >= 3000)
			n_fail = n_fail + 1;
		@(posedge sys_clk);
	end
	endtask

	// Reset values and an unmapped offset
	task t_reset;
	begin
		rdc("ctrl", `SDT_A_CTRL, 32'h0000_0000);
		rdc("enable", `SDT_A_ENABLE, 32'h0000_0000);
		rdc("error", `SDT_A_ERROR, 32'h0000_0000);
		rdc("pc0", 16'h0020, 32'h0000_0000);
		xfer(16'h0100, 1'b1, 32'hFFFF_FFFF);
		rdc("unmapped", 16'h0100, 32'h0000_0000);
	end
	endtask

	// Moves, reads and writes on channel 0, closed by the cleared word after them, whose primary opcode is undefined
	task t_prog;
	begin
		ramw(12'h104, 32'hAB00_00CD);
		ramw(12'h105, 32'h7700_0000);
		ramw(12'h102, 32'h5500_0000);
		ramw(12'h000, 32'h1100_0000);
		ramw(12'h001, 32'hA380_0000);
		ramw(12'h002, 32'hA3F2_C400); // Don't-care B and address bits set
		ramw(12'h003, 32'h1212_3456);
		ramw(12'h004, 32'hAF01_0410);
		ramw(12'h005, 32'hA202_0404);
		ramw(12'h006, 32'hA401_0414);
		ramw(12'h007, 32'hA207_0408);
		ramw(12'h008, 32'hA580_0000);
		ramw(12'h009, 32'hA502_040C);
		ramw(12'h00A, 32'hA6D0_0000);
		ramw(12'h00B, 32'hA602_0418);
		ramw(12'h00C, 32'hA000_F000);
		ramw(12'h00D, 32'h1B00_00A5); // Set, then clear, shared trigger bits
		ramw(12'h00E, 32'h1A00_0021);
		xfer(`SDT_A_ENABLE, 1'b1, 32'h0000_0001);
		wait_off(0);
		chk("ch_err", {24'h00_0000, ch_err}, 32'h0000_0001);
		chk("ch_en", {24'h00_0000, ch_en}, 32'h0000_0000);
		rdc("error", `SDT_A_ERROR, 32'h0000_0001);
		rdc("trig", `SDT_A_TRIG, 32'h0000_0084);
		rdc("w100", 16'h4400, 32'h0000_0003);
		rdc("w101", 16'h4404, 32'hCD12_3456);
		rdc("w102", 16'h4408, 32'h5512_3456);
		rdc("w103", 16'h440C, 32'h7700_0003);
		rdc("w106", 16'h4418, {8'h77, ts1});
	end
	endtask

	// Instruction cycle length on channel 1 while the host reads RAM
	task t_timing(input [31:0] mode, input integer exp);
	begin
		xfer(`SDT_A_CTRL, 1'b1, mode);
		xfer(16'h0024, 1'b1, 32'h0000_0080);
		xfer(`SDT_A_ENABLE, 1'b1, 32'h0000_0002);
		rdc("error", `SDT_A_ERROR, 32'h0000_0001);
		rdc("shared", 16'h4410, 32'hAB00_00CD);
		wait_off(1);
		chk("cycle", t_b - t_a, exp);
		chk("ch_err", {24'h00_0000, ch_err}, 32'h0000_0003);
	end
	endtask

	initial
	begin
		repeat (4) @(posedge sys_clk);
		arst_n <= 1'b1;
		@(posedge sys_clk);
		t_reset;
		t_prog;
		for (w = 32; w < 48; w = w + 1)
			ramw(w[11:0], 32'hA000_0000);
		ramw(12'h030, 32'hA000_F000);
		t_timing(32'h0000_0000, 9);
		t_timing(32'h0000_0001, 5);
		final_report;
	end

	// Hang guard, well past the expected run
	initial
	begin
		#(50 * 40000);
		n_fail = n_fail + 1;
		final_report;
	end
endmodule
